// ---- core/main_system_clock_params.svh ----
// Offsets, field positions, reset values and counts of the clock block
`ifndef MAIN_SYSTEM_CLOCK_PARAMS_SVH
`define MAIN_SYSTEM_CLOCK_PARAMS_SVH
// Register word indexes (byte address = index * 4)
`define REG_CLK_CTRL   4'h0
`define REG_CLK_STAT   4'h1
`define REG_LF_CAL     4'h2
`define REG_WDOG_CTRL  4'h3
`define REG_WDOG_STAT  4'h4
`define REG_SLP_CFG    4'h5
`define REG_SLP_CNT    4'h6
`define REG_SLP_CMPA   4'h7
`define REG_SLP_CMPB   4'h8
`define REG_SLP_FLAGS  4'h9
// Clock control field positions
`define CC_XTAL_SEL    0
`define CC_CPU_SEL     1
`define CC_PIN_DIG     2
`define CC_EVT_SLEEP   3
// Sleep config field positions
`define SC_EXP_LSB     0
`define SC_SRC_32K     4
`define SC_PAUSE_HALT  5
`define SC_IEN_LSB     8
`define SC_WEN_LSB     12
// Reset values
`define RST_LF_STEP    16'h199a
`define RST_SLP_EXP    4'h1
// Watchdog figures, in milliseconds of the 1 kHz reference
`define REF_HZ         1000
`define WDOG_TIMEOUT_MS 2048
`define WDOG_WARN_MS   1792
`define WDOG_LAST  11'((`WDOG_TIMEOUT_MS * `REF_HZ / 1000) - 1)
`define WDOG_WARN  11'(`WDOG_WARN_MS * `REF_HZ / 1000)
// AXI responses
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`endif

// ---- core/main_system_clock_pkg.sv ----
// Types shared by the clock and system timer block
package main_system_clock_pkg;
  // CPU clock source, one-hot
  typedef enum logic [1:0] {
    CPU_FROM_PCLK   = 2'b01,
    CPU_FROM_MAIN_SYSTEM_CLOCK = 2'b10
  } cpu_src_t;
endpackage

// ---- core/main_system_clock_timers.sv ----
// Clock mode selection, 1 kHz reference, watchdog and sleep timer
// Notes on behaviour
// - 10 kHz RC divided fractionally to 1 kHz
// - Digital pin clock replaces watch crystal
// - Crystal select: 0 RC, 1 crystal
// - Peripheral clock is main clock halved
// - CPU select: 0 peripheral, 1 main clock
// - Flash busy forces 12 MHz CPU clock
// - Watchdog disabled at power-up, counts when enabled
// - Watchdog expires after 2.048 s
// - Early warning NMI at 1.792 s
// - Watchdog holds during debugger halt
// - 32-bit sleep timer, 1 kHz default
// - Prescaler divides by two to the N, N of 0 taken as 1
// - Two compares and wrap raise events
// - Sleep timer runs through halt by default
// - No RC and no crystal: timer stops
// - Event timer clock CPU or sleep
// - Crystal failure reverts to RC, NMI
`timescale 1ns/1ns
`include "main_system_clock_params.svh"
module main_system_clock_timers (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst_n,
  // AXI4-Lite write channels
  input  wire logic        i_awvalid,
  input  wire logic [7:0]  i_awaddr,
  output logic             o_awready,
  input  wire logic        i_wvalid,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  output logic             o_wready,
  output logic             o_bvalid,
  output logic [1:0]       o_bresp,
  input  wire logic        i_bready,
  // AXI4-Lite read channels
  input  wire logic        i_arvalid,
  input  wire logic [7:0]  i_araddr,
  output logic             o_arready,
  output logic             o_rvalid,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  input  wire logic        i_rready,
  // Oscillator and pin levels, asynchronous
  input  wire logic        i_low_freq_rc_osc,
  input  wire logic        i_low_freq_crystal_osc,
  input  wire logic        i_lf_clock_input_pin,
  input  wire logic        i_xtal_fail,
  // Same-clock status
  input  wire logic        i_lf_rc_on,
  input  wire logic        i_flash_busy,
  input  wire logic        i_dbg_halt,
  // Clock selection
  output logic             o_crystal_select,
  output logic [1:0]       o_cpu_clk_src,
  // Events to core and reset logic
  output logic             o_nmi,
  output logic             o_wdog_reset_req,
  output logic             o_sleep_irq,
  output logic             o_sleep_wake,
  output logic             o_evt_clk_from_sleep,
  output logic             o_evt_sleep_tick
);

  // Synchroniser index of each asynchronous input
  localparam int SRC = 0;
  localparam int SXT = 1;
  localparam int SPN = 2;
  localparam int SXF = 3;
  logic [2:0]  sy_r [4];      // Three-stage synchronisers
  logic [2:0]  sy_nxt [4];
  logic [3:0]  lvl_r, lvl_nxt; // Filtered levels
  logic [3:0]  rise;           // Filtered rising edges
  logic [3:0]  ctrl_r, ctrl_nxt; // Clock control bits
  logic        xfl_r, xfl_nxt;   // Crystal failure flag
  logic [15:0] step_r, step_nxt; // Fractional step
  logic [15:0] acc_r, acc_nxt;   // Fractional phase
  logic        wden_r, wden_nxt; // Watchdog enable
  logic [10:0] wdc_r, wdc_nxt;   // Watchdog count
  logic        warn_r, warn_nxt; // Early warning flag
  logic        wrq_r, wrq_nxt;   // Reset request pulse
  logic [3:0]  exp_r, exp_nxt;   // Prescaler exponent
  logic        s32_r, s32_nxt;   // Sleep source is 32 kHz
  logic        poh_r, poh_nxt;   // Pause on halt
  logic [2:0]  ien_r, ien_nxt;   // Interrupt enables
  logic [2:0]  wen_r, wen_nxt;   // Wake enables
  logic [14:0] pre_r, pre_nxt;   // Prescaler counter
  logic [31:0] scnt_r, scnt_nxt; // Sleep count
  logic [31:0] cmpa_r, cmpa_nxt;
  logic [31:0] cmpb_r, cmpb_nxt;
  logic [2:0]  sfl_r, sfl_nxt;   // Compare A, B, wrap flags
  logic        etk_r, etk_nxt;   // Event timer tick
  logic [1:0]  cpu_r, cpu_nxt;
  logic        bv_r, bv_nxt;
  logic [1:0]  br_r, br_nxt;
  logic        rv_r, rv_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic [1:0]  rr_r, rr_nxt;
  // Byte-lane merge of write data into an old value
  function automatic logic [31:0] wm(input logic [31:0] o,
      input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = d[8*b +: 8];
      end
    end
    return r;
  endfunction
  // Word index is mapped
  function automatic logic mapped(input logic [5:0] ix);
    return ix <= 6'(`REG_SLP_FLAGS);
  endfunction
  // Read value of one register
  function automatic logic [31:0] rdval(input logic [5:0] ix);
    logic [31:0] v;
    v = 32'h0;
    unique case (ix[3:0])
      `REG_CLK_CTRL:  v = {28'h0, ctrl_r};
      `REG_CLK_STAT:  v = {29'h0, i_flash_busy, xfl_r, ctrl_r[0]};
      `REG_LF_CAL:    v = {16'h0, step_r};
      `REG_WDOG_CTRL: v = {31'h0, wden_r};
      `REG_WDOG_STAT: v = {19'h0, warn_r, 1'b0, wdc_r};
      `REG_SLP_CFG:   v = {17'h0, wen_r, 1'b0, ien_r, 2'h0, poh_r,
                           s32_r, exp_r};
      `REG_SLP_CNT:   v = scnt_r;
      `REG_SLP_CMPA:  v = cmpa_r;
      `REG_SLP_CMPB:  v = cmpb_r;
      `REG_SLP_FLAGS: v = {29'h0, sfl_r};
      default:        v = 32'h0;
    endcase
    return v;
  endfunction

  // Bus handshakes: both write channels are taken together
  logic wr, rd;
  assign wr = i_awvalid & i_wvalid & ~bv_r;
  assign rd = i_arvalid & ~rv_r;
  assign o_awready = wr;
  assign o_wready  = wr;
  assign o_arready = rd;

  // Next state of the whole block
  always_comb begin
    logic [5:0]  wi;
    logic [31:0] wv, wc;
    logic        we, t1k, s32e, stk, run, rdy;
    logic [14:0] msk;
    logic [16:0] sum;
    logic [3:0]  n;
    sum = 17'h0;
    wi = i_awaddr[7:2];
    we = wr & mapped(wi);
    wv = wm(rdval(wi), i_wdata, i_wstrb);
    wc = wm(32'h0, i_wdata, i_wstrb);
    // Synchronisers; a change counts once stages two and three agree
    for (int k = 0; k < 4; k++) begin
      sy_nxt[k] = {sy_r[k][1:0], 1'b0};
      lvl_nxt[k] = (sy_r[k][1] == sy_r[k][2]) ? sy_r[k][2] : lvl_r[k];
      rise[k] = lvl_nxt[k] & ~lvl_r[k];
    end
    sy_nxt[SRC][0] = i_low_freq_rc_osc;
    sy_nxt[SXT][0] = i_low_freq_crystal_osc;
    sy_nxt[SPN][0] = i_lf_clock_input_pin;
    sy_nxt[SXF][0] = i_xtal_fail;
    // Hold by default
    ctrl_nxt = ctrl_r; xfl_nxt = xfl_r; step_nxt = step_r;
    wden_nxt = wden_r; wdc_nxt = wdc_r; warn_nxt = warn_r;
    exp_nxt = exp_r; s32_nxt = s32_r; poh_nxt = poh_r;
    ien_nxt = ien_r; wen_nxt = wen_r; cmpa_nxt = cmpa_r;
    cmpb_nxt = cmpb_r; sfl_nxt = sfl_r; wrq_nxt = 1'b0;
    // Register writes
    if (we) begin
      unique case (wi[3:0])
        `REG_CLK_CTRL:  ctrl_nxt = wv[3:0];
        `REG_CLK_STAT:  xfl_nxt = xfl_r & ~wc[1];
        `REG_LF_CAL:    step_nxt = wv[15:0];
        `REG_WDOG_CTRL: wden_nxt = wv[0];
        `REG_WDOG_STAT: warn_nxt = warn_r & ~wc[12];
        `REG_SLP_CFG: begin
          exp_nxt = wv[`SC_EXP_LSB +: 4];
          s32_nxt = wv[`SC_SRC_32K];
          poh_nxt = wv[`SC_PAUSE_HALT];
          ien_nxt = wv[`SC_IEN_LSB +: 3];
          wen_nxt = wv[`SC_WEN_LSB +: 3];
        end
        `REG_SLP_CMPA:  cmpa_nxt = wv;
        `REG_SLP_CMPB:  cmpb_nxt = wv;
        `REG_SLP_FLAGS: sfl_nxt = sfl_r & ~wc[2:0];
        default: ;
      endcase
    end
    // revert on failure
    // Failure beats a same-cycle software select of the crystal
    if (rise[SXF]) begin
      ctrl_nxt[`CC_XTAL_SEL] = 1'b0;
      xfl_nxt = 1'b1;
    end
    // fractional divider
    // Phase wraps about once per ten RC edges; step is trimmable
    acc_nxt = acc_r;
    t1k = 1'b0;
    if (rise[SRC] & i_lf_rc_on) begin
      sum = {1'b0, acc_r} + {1'b0, step_r};
      acc_nxt = sum[15:0];
      t1k = sum[16];
    end
    if (we && wi[3:0] == `REG_WDOG_CTRL && wv[1]) begin
      // Kick restarts the count
      wdc_nxt = 11'h0;
    end else if (wden_r & t1k & ~i_dbg_halt) begin
      if (wdc_r == `WDOG_LAST) begin
        wdc_nxt = 11'h0;
        wrq_nxt = 1'b1;
      end else begin
        wdc_nxt = wdc_r + 11'h1;
      end
      if (wdc_r + 11'h1 == `WDOG_WARN) begin
        warn_nxt = 1'b1;
      end
    end
    s32e = ctrl_r[`CC_PIN_DIG] ? rise[SPN] : rise[SXT];
    stk = s32_r ? s32e : t1k;
    run = ~(poh_r & i_dbg_halt);
    n = (exp_r == 4'h0) ? 4'h1 : exp_r;
    msk = 15'((32'h1 << n) - 32'h1);
    pre_nxt = pre_r;
    scnt_nxt = scnt_r;
    rdy = 1'b0;
    if (stk & run) begin
      pre_nxt = pre_r + 15'h1;
      rdy = (pre_r & msk) == msk;
    end
    etk_nxt = rdy;
    if (rdy) begin
      scnt_nxt = scnt_r + 32'h1;
      sfl_nxt = sfl_nxt | {scnt_r == 32'hffff_ffff,
                           scnt_nxt == cmpb_r, scnt_nxt == cmpa_r};
    end
    if (i_flash_busy) begin
      cpu_nxt = ctrl_nxt[`CC_XTAL_SEL] ? main_system_clock_pkg::CPU_FROM_PCLK
                                       : main_system_clock_pkg::CPU_FROM_MAIN_SYSTEM_CLOCK;
    end else begin
      cpu_nxt = ctrl_nxt[`CC_CPU_SEL] ? main_system_clock_pkg::CPU_FROM_MAIN_SYSTEM_CLOCK
                                      : main_system_clock_pkg::CPU_FROM_PCLK;
    end
    // Write response
    bv_nxt = bv_r;
    br_nxt = br_r;
    if (wr) begin
      bv_nxt = 1'b1;
      br_nxt = mapped(wi) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bv_r & i_bready) begin
      bv_nxt = 1'b0;
    end
    // Read data
    rv_nxt = rv_r;
    rd_nxt = rd_r;
    rr_nxt = rr_r;
    if (rd) begin
      rv_nxt = 1'b1;
      rd_nxt = mapped(i_araddr[7:2]) ? rdval(i_araddr[7:2]) : 32'h0;
      rr_nxt = mapped(i_araddr[7:2]) ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rv_r & i_rready) begin
      rv_nxt = 1'b0;
    end
  end

  // Registers; watchdog starts disabled
  // disabled at power-up
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int k = 0; k < 4; k++) begin
        sy_r[k] <= 3'h0;
      end
      lvl_r <= 4'h0; ctrl_r <= 4'h0; xfl_r <= 1'b0;
      step_r <= `RST_LF_STEP; acc_r <= 16'h0;
      wden_r <= 1'b0; wdc_r <= 11'h0; warn_r <= 1'b0;
      wrq_r <= 1'b0; exp_r <= `RST_SLP_EXP; s32_r <= 1'b0;
      poh_r <= 1'b0; ien_r <= 3'h0; wen_r <= 3'h0;
      pre_r <= 15'h0; scnt_r <= 32'h0; cmpa_r <= 32'h0;
      cmpb_r <= 32'h0; sfl_r <= 3'h0; etk_r <= 1'b0;
      cpu_r <= main_system_clock_pkg::CPU_FROM_PCLK;
      bv_r <= 1'b0; br_r <= 2'h0; rv_r <= 1'b0;
      rd_r <= 32'h0; rr_r <= 2'h0;
    end else begin
      sy_r <= sy_nxt;
      lvl_r <= lvl_nxt; ctrl_r <= ctrl_nxt; xfl_r <= xfl_nxt;
      step_r <= step_nxt; acc_r <= acc_nxt;
      wden_r <= wden_nxt; wdc_r <= wdc_nxt; warn_r <= warn_nxt;
      wrq_r <= wrq_nxt; exp_r <= exp_nxt; s32_r <= s32_nxt;
      poh_r <= poh_nxt; ien_r <= ien_nxt; wen_r <= wen_nxt;
      pre_r <= pre_nxt; scnt_r <= scnt_nxt; cmpa_r <= cmpa_nxt;
      cmpb_r <= cmpb_nxt; sfl_r <= sfl_nxt; etk_r <= etk_nxt;
      cpu_r <= cpu_nxt;
      bv_r <= bv_nxt; br_r <= br_nxt; rv_r <= rv_nxt;
      rd_r <= rd_nxt; rr_r <= rr_nxt;
    end
  end

  // Outputs, all from flops
  // main clock source
  assign o_crystal_select = ctrl_r[`CC_XTAL_SEL];
  assign o_cpu_clk_src = cpu_r;
  assign o_nmi = warn_r | xfl_r;
  assign o_wdog_reset_req = wrq_r;
  assign o_sleep_irq = |(sfl_r & ien_r);
  assign o_sleep_wake = |(sfl_r & wen_r);
  assign o_evt_clk_from_sleep = ctrl_r[`CC_EVT_SLEEP];
  assign o_evt_sleep_tick = etk_r;
  assign o_bvalid = bv_r;
  assign o_bresp = br_r;
  assign o_rvalid = rv_r;
  assign o_rdata = rd_r;
  assign o_rresp = rr_r;

endmodule // main_system_clock_timers

// ---- tb/main_system_clock_osc_model.sv ----
// Free-running low-frequency oscillator and pin clock levels
`timescale 1ns/1ns
module main_system_clock_osc_model (
  // Oscillator levels
  output logic o_rc,
  output logic o_x32k,
  output logic o_pin
);
  // RC reference, sped up to keep watchdog runs short
  initial begin
    o_rc = 1'b0;
    forever #170 o_rc = ~o_rc;
  end
  // crystal and external pin clock, same rate, fixed phase offset
  initial begin
    o_x32k = 1'b0;
    o_pin  = 1'b1;
    forever begin
      #611 o_x32k = ~o_x32k;
      #122 o_pin  = ~o_pin;
    end
  end
endmodule // main_system_clock_osc_model

// ---- tb/main_system_clock_timers_assertions.sv ----
// Concurrent checks on the clock and system timer ports
`timescale 1ns/1ns
module main_system_clock_timers_chk (
  // Clock, reset, bus requests and status inputs
  input wire logic       i_core_clk,
  input wire logic       i_rst_n,
  input wire logic       i_awvalid,
  input wire logic       i_wvalid,
  input wire logic       i_arvalid,
  input wire logic       i_xtal_fail,
  input wire logic       i_flash_busy,
  input wire logic       i_dbg_halt,
  // Answers and events
  input wire logic       o_bvalid,
  input wire logic       o_rvalid,
  input wire logic       o_crystal_select,
  input wire logic [1:0] o_cpu_clk_src,
  input wire logic       o_nmi,
  input wire logic       o_wdog_reset_req,
  input wire logic       o_evt_sleep_tick,
  input wire logic       o_sleep_irq
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  a_reset_state: assert property ($rose(i_rst_n) |-> o_cpu_clk_src == 2'b01
    && !o_crystal_select && !o_wdog_reset_req)
    else $error("state after reset wrong");
  a_write_answer: assert property (i_awvalid && i_wvalid && !o_bvalid
    |=> o_bvalid) else $error("write not answered");
  a_read_answer: assert property (i_arvalid && !o_rvalid |=> o_rvalid)
    else $error("read not answered");
  a_flash_force: assert property (i_flash_busy && $past(i_flash_busy) &&
    $stable(o_crystal_select) |-> o_cpu_clk_src ==
    (o_crystal_select ? 2'b01 : 2'b10)) else $error("flash clock wrong");
  a_xtal_revert: assert property ($rose(i_xtal_fail) |-> ##[1:6]
    (!o_crystal_select && o_nmi)) else $error("no crystal failover");
  a_wdog_pulse: assert property (o_wdog_reset_req |=>
    !o_wdog_reset_req) else $error("reset request too long");
  a_halt_hold: assert property (i_dbg_halt[*3] |->
    !o_wdog_reset_req) else $error("watchdog ran while halted");
  a_tick_pulse: assert property (o_evt_sleep_tick |=>
    !o_evt_sleep_tick) else $error("sleep tick too long");
  // Main scenarios reached
  c_expiry: cover property (o_wdog_reset_req);
  c_warn: cover property ($rose(o_nmi));
  c_sleep_irq: cover property ($rose(o_sleep_irq));
endmodule // main_system_clock_timers_chk
bind main_system_clock_timers main_system_clock_timers_chk i_main_system_clock_timers_chk (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_awvalid(i_awvalid),
  .i_wvalid(i_wvalid), .i_arvalid(i_arvalid), .i_xtal_fail(i_xtal_fail),
  .i_flash_busy(i_flash_busy), .i_dbg_halt(i_dbg_halt),
  .o_bvalid(o_bvalid), .o_rvalid(o_rvalid),
  .o_crystal_select(o_crystal_select), .o_cpu_clk_src(o_cpu_clk_src),
  .o_nmi(o_nmi), .o_wdog_reset_req(o_wdog_reset_req),
  .o_evt_sleep_tick(o_evt_sleep_tick), .o_sleep_irq(o_sleep_irq));

// ---- tb/main_system_clock_timers_tb_top.sv ----
// Self-checking bench for the clock and system timer block
`timescale 1ns/1ns
`include "main_system_clock_params.svh"
module main_system_clock_timers_tb_top;
  // Expected bus answer: mask, data, response
  typedef struct {logic [31:0] m; logic [31:0] d; logic [1:0] r;} note_t;
  note_t       notes[$];
  note_t       nt;
  logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, q, seed;
  logic        xtal_fail, flash_busy, dbg_halt, lf_rc_on, rc, x32k, pin;
  logic        awready, wready, bvalid, arready, rvalid, xsel, nmi, wrst;
  logic        irq, wake, evt_src, evt_tick;
  logic [1:0]  bresp, rresp, cpu_src, m;
  int          n_errors, check_count, i, n;
  main_system_clock_osc_model i_main_system_clock_osc_model (.o_rc(rc), .o_x32k(x32k), .o_pin(pin));
  main_system_clock_timers i_main_system_clock_timers (
    .i_core_clk(clk), .i_rst_n(rst_n), .i_awvalid(awvalid),
    .i_awaddr(awaddr), .o_awready(awready), .i_wvalid(wvalid),
    .i_wdata(wdata), .i_wstrb(4'hf), .o_wready(wready), .o_bvalid(bvalid),
    .o_bresp(bresp), .i_bready(bready), .i_arvalid(arvalid),
    .i_araddr(araddr), .o_arready(arready), .o_rvalid(rvalid),
    .o_rdata(rdata), .o_rresp(rresp), .i_rready(rready),
    .i_low_freq_rc_osc(rc), .i_low_freq_crystal_osc(x32k),
    .i_lf_clock_input_pin(pin), .i_xtal_fail(xtal_fail),
    .i_lf_rc_on(lf_rc_on), .i_flash_busy(flash_busy), .i_dbg_halt(dbg_halt),
    .o_crystal_select(xsel), .o_cpu_clk_src(cpu_src), .o_nmi(nmi),
    .o_wdog_reset_req(wrst), .o_sleep_irq(irq), .o_sleep_wake(wake),
    .o_evt_clk_from_sleep(evt_src), .o_evt_sleep_tick(evt_tick));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Random words from a fixed-start shift register
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic complete_run();
    if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input string nm, input logic [1:0] e, g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s exp %h seen %h", nm, e, g);
    end
  endtask
  // Write: address and data offered together, held until taken
  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    @(posedge clk);
    notes.push_back('{32'h0, 32'h0, r});
    awaddr <= {2'b00, a, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do @(posedge clk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    while (bvalid !== 1'b1) @(posedge clk);
    bready <= 1'b0;
  endtask
  // Read: word captured at the edge that takes the answer
  task automatic rd(input logic [3:0] a, input logic [31:0] mk, d,
                    input logic [1:0] r, output logic [31:0] v);
    @(posedge clk);
    notes.push_back('{mk, d, r});
    araddr <= {2'b00, a, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge clk);
    v = rdata;
    rready <= 1'b0;
  endtask
  // Monitor: oldest note against each bus answer taken
  always @(posedge clk) begin
    if ((rvalid && rready) || (bvalid && bready)) begin
      nt = notes.pop_front();
      check_count++;
      if (((rvalid ? rdata : 32'h0) & nt.m) !== nt.d ||
          (rvalid ? rresp : bresp) !== nt.r) begin
        n_errors++;
        $display("unexpected bus answer exp %h %h seen %h %h", nt.d, nt.r,
                 rvalid ? rdata : 32'h0, rvalid ? rresp : bresp);
      end
    end
  end
  // Watchdog on the bench: a hang ends as a failure
  initial begin
    repeat (50000) @(posedge clk);
    n_errors++;
    complete_run();
  end
  initial begin
    {rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {xtal_fail, flash_busy, dbg_halt, awaddr, araddr, wdata} = 51'h0;
    lf_rc_on = 1'b1;
    seed = 32'h09e8;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(`REG_LF_CAL, 32'hffff, `RST_LF_STEP, `RESP_OKAY, q);
    rd(`REG_SLP_CFG, 32'h773f, 32'h1, `RESP_OKAY, q);
    rd(`REG_WDOG_CTRL, 32'h1, 32'h0, `RESP_OKAY, q);
    rd(4'ha, 32'h0, 32'h0, `RESP_SLVERR, q);
    wr(4'ha, 32'h0, `RESP_SLVERR);
    // Every clock mode, then the same mode under flash busy
    for (i = 0; i < 4; i++) begin
      m = i[1:0];
      wr(`REG_CLK_CTRL, {28'h0, m[1], 1'b0, m}, `RESP_OKAY);
      repeat (2) @(posedge clk);
      check("xtal_sel", {1'b0, m[0]}, {1'b0, xsel});
      check("cpu_src", m[1] ? 2'b10 : 2'b01, cpu_src);
      check("evt_src", {1'b0, m[1]}, {1'b0, evt_src});
      flash_busy <= 1'b1;
      repeat (3) @(posedge clk);
      check("flash_src", m[0] ? 2'b01 : 2'b10, cpu_src);
      flash_busy <= 1'b0;
    end
    // Crystal failure while the crystal drives the main clock
    // fast crystal mode, as software should run
    wr(`REG_CLK_CTRL, 32'h3, `RESP_OKAY);
    xtal_fail <= 1'b1;
    repeat (8) @(posedge clk);
    check("xtal_sel", 2'b00, {1'b0, xsel});
    check("nmi", 2'b01, {1'b0, nmi});
    check("cpu_src", 2'b10, cpu_src);
    xtal_fail <= 1'b0;
    rd(`REG_CLK_STAT, 32'h3, 32'h2, `RESP_OKAY, q);
    wr(`REG_CLK_STAT, 32'h2, `RESP_OKAY);
    // Fast 1 kHz ticks, then compare A raises irq and wake
    wr(`REG_LF_CAL, 32'hffff, `RESP_OKAY);
    rd(`REG_SLP_CNT, 32'h0, 32'h0, `RESP_OKAY, q);
    wr(`REG_SLP_CMPA, q + 32'h8, `RESP_OKAY);
    wr(`REG_SLP_CFG, 32'h1101, `RESP_OKAY);
    for (n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge clk);
    check("sleep_irq", 2'b01, {1'b0, irq});
    check("sleep_wake", 2'b01, {1'b0, wake});
    rd(`REG_SLP_FLAGS, 32'h1, 32'h1, `RESP_OKAY, q);
    wr(`REG_SLP_FLAGS, 32'h7, `RESP_OKAY);
    check("sleep_irq", 2'b00, {1'b0, irq});
    seed = lfsr(seed);
    wr(`REG_SLP_CMPB, seed, `RESP_OKAY);
    rd(`REG_SLP_CMPB, 32'hffffffff, seed, `RESP_OKAY, q);
    // RC stopped: the 1 kHz sleep count freezes
    lf_rc_on <= 1'b0;
    wr(`REG_SLP_CFG, 32'h0201, `RESP_OKAY);
    rd(`REG_SLP_CNT, 32'h0, 32'h0, `RESP_OKAY, q);
    repeat (200) @(posedge clk);
    rd(`REG_SLP_CNT, 32'hffffffff, q, `RESP_OKAY, q);
    // pin clock while halted drives compare B
    wr(`REG_SLP_CMPB, q + 32'h2, `RESP_OKAY);
    wr(`REG_CLK_CTRL, 32'h4, `RESP_OKAY);
    dbg_halt <= 1'b1;
    // 32 kHz divided by 2^5 gives 1024 Hz
    wr(`REG_SLP_CFG, 32'h0215, `RESP_OKAY);
    for (n = 0; n < 6000 && irq !== 1'b1; n++) @(posedge clk);
    check("sleep_irq", 2'b01, {1'b0, irq});
    // optional pause on halt holds the count
    wr(`REG_SLP_CFG, 32'h0235, `RESP_OKAY);
    rd(`REG_SLP_CNT, 32'h0, 32'h0, `RESP_OKAY, q);
    repeat (2500) @(posedge clk);
    rd(`REG_SLP_CNT, 32'hffffffff, q, `RESP_OKAY, q);
    dbg_halt <= 1'b0;
    lf_rc_on <= 1'b1;
    // after wake, wait one tick before use
    for (n = 0; n < 3000 && evt_tick !== 1'b1; n++) @(posedge clk);
    // sleep tick for the event timer
    check("evt_tick", 2'b01, {1'b0, evt_tick});
    wr(`REG_SLP_FLAGS, 32'h7, `RESP_OKAY);
    // Watchdog: idle while off, kick, warning, halt, expiry
    // no count before enable
    rd(`REG_WDOG_STAT, 32'h7ff, 32'h0, `RESP_OKAY, q);
    wr(`REG_WDOG_CTRL, 32'h1, `RESP_OKAY);
    repeat (400) @(posedge clk);
    wr(`REG_WDOG_CTRL, 32'h3, `RESP_OKAY);
    rd(`REG_WDOG_STAT, 32'h7f0, 32'h0, `RESP_OKAY, q);
    for (n = 0; n < 40000 && nmi !== 1'b1; n++) @(posedge clk);
    dbg_halt <= 1'b1;
    rd(`REG_WDOG_STAT, 32'h17f0, 32'h1700, `RESP_OKAY, q);
    repeat (100) @(posedge clk);
    rd(`REG_WDOG_STAT, 32'hffffffff, q, `RESP_OKAY, q);
    dbg_halt <= 1'b0;
    for (n = 0; n < 8000 && wrst !== 1'b1; n++) @(posedge clk);
    check("wdog_rst", 2'b01, {1'b0, wrst});
    rd(`REG_WDOG_STAT, 32'h7f0, 32'h0, `RESP_OKAY, q);
    wr(`REG_WDOG_CTRL, 32'h0, `RESP_OKAY);
    rd(`REG_WDOG_STAT, 32'h0, 32'h0, `RESP_OKAY, q);
    repeat (100) @(posedge clk);
    rd(`REG_WDOG_STAT, 32'h7ff, q & 32'h7ff, `RESP_OKAY, q);
    wr(`REG_WDOG_STAT, 32'h1000, `RESP_OKAY);
    check("nmi", 2'b00, {1'b0, nmi});
    complete_run();
  end
endmodule // main_system_clock_timers_tb_top
